/* hpm_defines.svh */
// Constants of the pass-through handle manager: command codes, status codes, field layout, timing.
// Assumes a 50 MHz system clock and four field-device channels.
`ifndef HPM_DEFINES_SVH
`define HPM_DEFINES_SVH

`define HPM_NUM_CHAN 4
`define HPM_CMD_REQUEST 8'h01
`define HPM_CMD_QUERY 8'h0C
`define HPM_DELIM_LONG 8'h82
`define HPM_ST_SUCCESS 8'h00
`define HPM_ST_BUSY 8'h20
`define HPM_ST_ACCEPTED 8'h21
`define HPM_ST_PENDING 8'h22
`define HPM_ST_REFUSED 8'h23
`define HPM_HANDLE_NONE 8'h00
`define HPM_HANDLE_FIRST 8'h01
`define HPM_HANDLE_LAST 8'hFF
`define HPM_COUNT_HANDLE 16'h0001
`define HPM_ADDR_BITS 38
// Request bytes before the PDU data: channel, command, delimiter, address(5), cmd, count
`define HPM_REQ_FIXED_BYTES 10
// Checksum trailer byte
`define HPM_REQ_TAIL_BYTES 1
`define HPM_CLK_HZ 50000000
`define HPM_TICK_SEC 1
`define HPM_SEC_CYCLES (`HPM_TICK_SEC * `HPM_CLK_HZ)

`endif

/* hpm_pkg.sv */
// Types shared by the pass-through handle manager modules.
// Assumes hpm_defines.svh provides the numeric constants.
package hpm_pkg;
   typedef enum logic [1:0] {SL_IDLE, SL_RUN, SL_HOLD} hpm_slot_st_t;
   typedef struct packed {
      hpm_slot_st_t st;
      logic [1:0] ch;
      logic [7:0] hdl;
      logic [15:0] len;
      logic [7:0] secs;
   } hpm_slot_t;
endpackage

/* hpm_chk_if.sv */
// Carries the channel qualification between the manager and the request checker.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface hpm_chk_if;
   logic [7:0] chan;
   logic [7:0] words;
   logic [7:0] delim;
   logic [39:0] addr;
   logic [7:0] data_cnt;
   logic chan_ok;
   logic frame_ok;
   modport mgr (output chan, words, delim, addr, data_cnt, input chan_ok, frame_ok);
   modport chk (input chan, words, delim, addr, data_cnt, output chan_ok, frame_ok);
endinterface
`default_nettype wire

/* hpm_req_check.sv */
// Qualifies a channel and a pass-through frame for the handle manager.
// Assumes per-channel state vectors are stable in the arrival cycle.
`timescale 1ns/100ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_req_check #(
   parameter int NCH = `HPM_NUM_CHAN
) (
   hpm_chk_if.chk chk,                        // Qualification carrier
   input wire logic [NCH-1:0] i_chan_en,      // Channel enabled
   input wire logic [NCH-1:0] i_addr_known,   // Unique address determined
   input wire logic [NCH-1:0] i_info_busy,    // Device info gathering active
   input wire logic [NCH*40-1:0] i_dev_addr   // Known long addresses, channel 0 low
);
   import hpm_pkg::*;
   wire chan_in_range = chk.chan < 8'(NCH);
   wire [1:0] ch = chk.chan[1:0];
   wire [39:0] known = i_dev_addr[ch*40 +: 40];
   // Word count in 16-bit words; widened so a full packet never wraps
   wire [9:0] have_bytes = {1'b0, chk.words, 1'b0};
   wire [9:0] need_bytes = 10'(`HPM_REQ_FIXED_BYTES) + {2'b00, chk.data_cnt}
                           + 10'(`HPM_REQ_TAIL_BYTES);
   // Master bit is not part of the device identity
   wire addr_ok = chk.addr[`HPM_ADDR_BITS-1:0] == known[`HPM_ADDR_BITS-1:0];
   assign chk.chan_ok = chan_in_range && i_chan_en[ch] && i_addr_known[ch]
                        && !i_info_busy[ch];
   assign chk.frame_ok = addr_ok && chk.delim == `HPM_DELIM_LONG
                         && have_bytes >= need_bytes;
endmodule // hpm_req_check
`default_nettype wire

/* hpm_sec_tick.sv */
// One-second enable pulse for handle timeouts.
// Assumes a free-running system clock.
`timescale 1ns/100ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_sec_tick #(
   parameter int SEC_CYCLES = `HPM_SEC_CYCLES
) (
   input wire logic i_clk,   // System clock
   input wire logic i_rstn,  // Async reset, active low
   output logic o_tick       // One-cycle pulse each second
);
   logic [31:0] cnt;
   wire wrap = cnt == 32'(SEC_CYCLES - 1);
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 32'h0;
         o_tick <= 1'b0;
      end else begin
         cnt <= wrap ? 32'h0 : cnt + 32'h1;
         o_tick <= wrap;
      end
   end
endmodule // hpm_sec_tick
`default_nettype wire

/* hpm_handle_mgr.sv */
// Pass-through request and completion query interpreter with a two-slot handle table.
// Assumes one message per strobe; the field-device engine reports results by handle.
`timescale 1ns/100ps
`default_nettype none
`include "hpm_defines.svh"
module hpm_handle_mgr #(
   parameter int NCH = `HPM_NUM_CHAN,
   parameter int SEC_CYCLES = `HPM_SEC_CYCLES
) (
   input wire logic i_clk,                    // 50 MHz clock
   input wire logic i_rstn,                   // Async reset, active low
   input wire logic i_msg_valid,              // Message strobe, one cycle
   input wire logic [7:0] i_msg_chan,         // Channel byte
   input wire logic [7:0] i_msg_cmd,          // Module command byte
   input wire logic [7:0] i_msg_handle,       // Query handle
   input wire logic [7:0] i_msg_words,        // Received message word count
   input wire logic [7:0] i_pdu_delim,        // PDU delimiter
   input wire logic [39:0] i_pdu_addr,        // PDU long address
   input wire logic [7:0] i_pdu_data_cnt,     // PDU request data count
   input wire logic [NCH-1:0] i_chan_en,      // Channel enabled
   input wire logic [NCH-1:0] i_addr_known,   // Unique address determined
   input wire logic [NCH-1:0] i_info_busy,    // Device info gathering
   input wire logic [NCH*40-1:0] i_dev_addr,  // Known long addresses
   input wire logic [7:0] i_timeout_sec,      // Handle timeout, seconds
   input wire logic i_fwd_done,               // Field reply ready, one cycle
   input wire logic [7:0] i_fwd_handle,       // Handle of that reply
   input wire logic [15:0] i_fwd_len,         // Reply bytes without preamble
   output logic o_fwd_valid,                  // Forward command pulse
   output logic [1:0] o_fwd_chan,             // Forward channel
   output logic [7:0] o_fwd_handle,           // Forward handle
   output logic o_rsp_valid,                  // Reply pulse
   output logic [7:0] o_rsp_chan,             // Reply channel
   output logic [7:0] o_rsp_status,           // Reply status
   output logic [15:0] o_rsp_count,           // Reply count
   output logic [7:0] o_rsp_handle,           // Reply handle
   output logic o_rsp_data,                   // Response data follows reply
   output logic [NCH-1:0] o_chan_pending      // Channel holds an active handle
);
   import hpm_pkg::*;

   hpm_chk_if chk ();
   hpm_slot_t slot [2];
   logic [7:0] hnext;
   logic tick;

   function automatic logic [7:0] hpm_inc(input logic [7:0] h);
      return (h == `HPM_HANDLE_LAST) ? `HPM_HANDLE_FIRST : h + 8'h01;
   endfunction

   function automatic logic slot_on(input hpm_slot_t s);
      return s.st != SL_IDLE;
   endfunction

   assign chk.chan = i_msg_chan;
   assign chk.words = i_msg_words;
   assign chk.delim = i_pdu_delim;
   assign chk.addr = i_pdu_addr;
   assign chk.data_cnt = i_pdu_data_cnt;

   hpm_req_check #(.NCH(NCH)) u_chk (
      .chk(chk.chk),
      .i_chan_en(i_chan_en),
      .i_addr_known(i_addr_known),
      .i_info_busy(i_info_busy),
      .i_dev_addr(i_dev_addr)
   );

   hpm_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .o_tick(tick)
   );

   // Decisions use the table as it stands in the arrival cycle
   wire [1:0] ch = i_msg_chan[1:0];
   wire on0 = slot_on(slot[0]);
   wire on1 = slot_on(slot[1]);
   wire own0 = on0 && slot[0].ch == ch;
   wire own1 = on1 && slot[1].ch == ch;
   wire is_req = i_msg_valid && i_msg_cmd == `HPM_CMD_REQUEST;
   wire is_qry = i_msg_valid && !is_req;
   wire qry_ok = i_msg_cmd == `HPM_CMD_QUERY && chk.chan_ok
                 && i_msg_handle != `HPM_HANDLE_NONE;
   wire hit0 = qry_ok && own0 && slot[0].hdl == i_msg_handle;
   wire hit1 = qry_ok && own1 && slot[1].hdl == i_msg_handle;
   wire hit_sel = hit1;
   wire hit = hit0 || hit1;
   wire hit_hold = hit && slot[hit_sel].st == SL_HOLD;
   wire req_ok = chk.chan_ok && chk.frame_ok && !own0 && !own1;
   wire full = on0 && on1;
   wire accept = is_req && req_ok && !full;
   wire free_sel = on0;
   // Only one other slot can be live at acceptance, so one skip is enough
   wire [7:0] hcand = ((on0 && slot[0].hdl == hnext) || (on1 && slot[1].hdl == hnext))
                      ? hpm_inc(hnext) : hnext;

   logic [7:0] next_status;
   logic [15:0] next_count;
   logic [7:0] next_handle;
   always_comb begin
      next_status = `HPM_ST_REFUSED;
      next_count = `HPM_COUNT_HANDLE;
      next_handle = `HPM_HANDLE_NONE;
      if (is_req) begin
         if (req_ok && full) begin
            next_status = `HPM_ST_BUSY;
         end else if (accept) begin
            next_status = `HPM_ST_ACCEPTED;
            next_handle = hcand;
         end
      end else begin
         next_handle = i_msg_handle;
         if (hit_hold) begin
            next_status = `HPM_ST_SUCCESS;
            next_count = `HPM_COUNT_HANDLE + slot[hit_sel].len;
         end else if (hit) begin
            next_status = `HPM_ST_PENDING;
         end
         // Anything else stays refused: bad command, handle, channel or expiry
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rsp_valid <= 1'b0;
         o_rsp_chan <= 8'h00;
         o_rsp_status <= `HPM_ST_REFUSED;
         o_rsp_count <= 16'h0000;
         o_rsp_handle <= `HPM_HANDLE_NONE;
         o_rsp_data <= 1'b0;
      end else begin
         o_rsp_valid <= i_msg_valid;
         if (i_msg_valid) begin
            o_rsp_chan <= i_msg_chan;
            o_rsp_status <= next_status;
            o_rsp_count <= next_count;
            o_rsp_handle <= next_handle;
            o_rsp_data <= is_qry && hit_hold;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fwd_valid <= 1'b0;
         o_fwd_chan <= 2'b00;
         o_fwd_handle <= `HPM_HANDLE_NONE;
         hnext <= `HPM_HANDLE_FIRST;
      end else begin
         o_fwd_valid <= accept;
         if (accept) begin
            o_fwd_chan <= ch;
            o_fwd_handle <= hcand;
            hnext <= hpm_inc(hcand);
         end
      end
   end

   // A finished reply with a zero timeout setting is still kept one tick
   wire [7:0] secs_load = (i_timeout_sec == 8'h00) ? 8'h01 : i_timeout_sec;

   for (genvar s = 0; s < 2; s++) begin : g_slot
      wire take = accept && free_sel == 1'(s);
      wire done = i_fwd_done && slot[s].st == SL_RUN && slot[s].hdl == i_fwd_handle;
      wire read = is_qry && hit_hold && hit_sel == 1'(s);
      wire expire = slot[s].st == SL_HOLD && tick && slot[s].secs == 8'h01;
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            slot[s] <= '{st: SL_IDLE, ch: 2'b00, hdl: 8'h00, len: 16'h0000, secs: 8'h00};
         end else begin
            case (slot[s].st)
               SL_IDLE: begin
                  if (take) begin
                     slot[s].st <= SL_RUN;
                     slot[s].ch <= ch;
                     slot[s].hdl <= hcand;
                  end
               end
               SL_RUN: begin
                  if (done) begin
                     slot[s].st <= SL_HOLD;
                     slot[s].len <= i_fwd_len;
                     slot[s].secs <= secs_load;
                  end
               end
               SL_HOLD: begin
                  if (read || expire) begin
                     slot[s].st <= SL_IDLE;
                  end else if (tick) begin
                     slot[s].secs <= slot[s].secs - 8'h01;
                  end
               end
               default: slot[s].st <= SL_IDLE;
            endcase
         end
      end
   end

   always_comb begin
      o_chan_pending = '0;
      for (int c = 0; c < NCH; c++) begin
         o_chan_pending[c] = (on0 && slot[0].ch == 2'(c)) || (on1 && slot[1].ch == 2'(c));
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_accept_handle: assert property (
      accept |=> o_rsp_status == `HPM_ST_ACCEPTED && o_rsp_handle != 8'h00 && o_fwd_valid)
      else $error("accepted request without nonzero handle");
   chk_refuse_zero: assert property (
      (o_rsp_valid && o_rsp_status == `HPM_ST_REFUSED && $past(is_req)) |-> o_rsp_handle == 8'h00)
      else $error("refused request carries a handle");
   chk_chan_gate: assert property (
      (is_req && !chk.chan_ok) |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("request on unqualified channel not refused");
   chk_info_busy: assert property (
      (i_msg_valid && i_info_busy[ch] && i_msg_chan < 8'(NCH))
         |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("device info busy not refused");
   chk_frame_bad: assert property (
      (is_req && !chk.frame_ok) |=> !o_fwd_valid)
      else $error("bad frame forwarded");
   chk_pending_once: assert property (
      (is_req && (own0 || own1)) |=> o_rsp_status == `HPM_ST_REFUSED && !o_fwd_valid)
      else $error("second handle on a pending channel");
   chk_busy_full: assert property (
      (is_req && req_ok && full) |=> o_rsp_status == `HPM_ST_BUSY)
      else $error("full queue not busy");
   chk_success_free: assert property (
      (is_qry && hit_hold) |=> o_rsp_status == 8'h00
         && ($past(hit_sel) ? slot[1].st : slot[0].st) == SL_IDLE
         && o_rsp_count == $past(slot[hit_sel].len) + 16'h0001)
      else $error("success did not free handle or count wrong");
   chk_running_quiet: assert property (
      (is_qry && hit && !hit_hold) |=> o_rsp_status == `HPM_ST_PENDING && !o_fwd_valid)
      else $error("running query misreported");
   chk_no_zero: assert property (
      o_fwd_valid |-> o_fwd_handle != 8'h00 && !(on0 && on1 && slot[0].hdl == slot[1].hdl))
      else $error("zero or duplicate handle");
   chk_rsp_follows: assert property (
      i_msg_valid |=> o_rsp_valid && o_rsp_chan == $past(i_msg_chan))
      else $error("message not answered in the next cycle");
   chk_rsp_single: assert property (
      !i_msg_valid |=> !o_rsp_valid)
      else $error("reply without a message");
   chk_addr_unknown: assert property (
      (i_msg_valid && !i_addr_known[ch] && i_msg_chan < 8'(NCH))
         |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("unknown device address not refused");
   chk_chan_off: assert property (
      (i_msg_valid && !i_chan_en[ch]) |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("disabled channel not refused");
   chk_chan_range: assert property (
      (i_msg_valid && i_msg_chan >= 8'(NCH)) |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("out of range channel not refused");
   chk_bad_cmd: assert property (
      (is_qry && i_msg_cmd != `HPM_CMD_QUERY)
         |=> o_rsp_status == `HPM_ST_REFUSED && o_rsp_handle == $past(i_msg_handle))
      else $error("invalid command not refused");
   chk_zero_query: assert property (
      (is_qry && i_msg_handle == `HPM_HANDLE_NONE) |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("zero handle query not refused");
   chk_delim_bad: assert property (
      (is_req && i_pdu_delim != `HPM_DELIM_LONG) |=> o_rsp_status == `HPM_ST_REFUSED)
      else $error("wrong delimiter not refused");
   chk_no_success: assert property (
      (is_qry && !hit_hold) |=> o_rsp_status != `HPM_ST_SUCCESS && !o_rsp_data)
      else $error("success without a held result");
   chk_data_flag: assert property (
      o_rsp_valid |-> o_rsp_data == (o_rsp_status == `HPM_ST_SUCCESS))
      else $error("data flag disagrees with status");
   chk_req_count: assert property (
      is_req |=> o_rsp_count == `HPM_COUNT_HANDLE && o_rsp_status != `HPM_ST_PENDING)
      else $error("request reply count not one");
   chk_fwd_match: assert property (
      o_fwd_valid |-> o_rsp_valid && o_rsp_status == `HPM_ST_ACCEPTED
         && o_rsp_handle == o_fwd_handle && o_rsp_chan[1:0] == o_fwd_chan)
      else $error("forward without matching accept reply");
   chk_count_short: assert property (
      (o_rsp_valid && o_rsp_status == `HPM_ST_PENDING) |-> o_rsp_count == `HPM_COUNT_HANDLE)
      else $error("running reply count not one");
   chk_handle_distinct: assert property (
      (on0 && on1) |-> slot[0].hdl != slot[1].hdl && hnext != `HPM_HANDLE_NONE)
      else $error("live handles collide");
   chk_live_nonzero: assert property (
      (on0 || on1) |-> (!on0 || slot[0].hdl != `HPM_HANDLE_NONE)
         && (!on1 || slot[1].hdl != `HPM_HANDLE_NONE))
      else $error("live slot holds handle zero");
   // Slot 0 stands for both slots: one generate body builds them alike
   chk_hold_keep: assert property (
      (slot[0].st == SL_HOLD && !tick && !(is_qry && hit_hold && !hit_sel))
         |=> slot[0].st == SL_HOLD)
      else $error("held reply dropped before its timeout");
   chk_expire_free: assert property (
      (slot[0].st == SL_HOLD && tick && slot[0].secs == 8'h01) |=> slot[0].st == SL_IDLE)
      else $error("expired handle not freed");
   chk_run_stays: assert property (
      (slot[0].st == SL_RUN && !i_fwd_done) |=> slot[0].st == SL_RUN)
      else $error("running handle left without a result");
   cov_accept: cover property (accept);
   cov_success: cover property (is_qry && hit_hold);
   cov_running: cover property (is_qry && hit && !hit_hold);
   cov_expire: cover property (slot[0].st == SL_HOLD ##1 slot[0].st == SL_IDLE && !$past(is_qry));
   cov_busy: cover property (is_req && req_ok && full);
endmodule // hpm_handle_mgr
`default_nettype wire

/* hpm_fwd_model.sv */
// Field-device engine stand-in: answers each forwarded command after a set delay.
// Assumes the handle manager pulses i_fwd_valid once per accepted request.
`timescale 1ns/100ps
`default_nettype none
module hpm_fwd_model #(
   parameter logic [15:0] LEN_BASE = 16'h0018
) (
   input wire logic i_clk,              // System clock
   input wire logic i_fwd_valid,        // Forward pulse from the manager
   input wire logic [1:0] i_fwd_chan,   // Channel forwarded
   input wire logic [7:0] i_fwd_handle, // Handle forwarded
   input wire logic [7:0] i_dly,        // Answer delay in cycles
   output logic o_done,                 // Reply ready pulse
   output logic [7:0] o_handle,         // Handle of the reply
   output logic [15:0] o_len            // Reply length, channel dependent
);
   initial begin
      o_done = 1'b0;
      o_handle = 8'h00;
      o_len = 16'h0000;
   end
   // Fields are inverted after the pulse so a stale value never passes for a fresh one
   task automatic reply(input logic [7:0] h, input logic [1:0] c);
      repeat (i_dly) @(posedge i_clk);
      #1 o_done = 1'b1;
      o_handle = h;
      o_len = LEN_BASE + 16'(c);
      @(posedge i_clk);
      #1 o_done = 1'b0;
      o_handle = ~h;
      o_len = ~o_len;
   endtask
   always @(posedge i_clk) begin
      #1;
      if (i_fwd_valid) begin
         fork
            reply(i_fwd_handle, i_fwd_chan);
         join_none
      end
   end
endmodule // hpm_fwd_model
`default_nettype wire

/* tb_top.sv */
// Bench for the handle manager: scenario tasks send host messages and judge each reply.
// Assumes hpm_fwd_model stands in for the field-device engine.
`timescale 1ns/100ps
`default_nettype none
`include "hpm_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   localparam logic [15:0] LEN = 16'h0018;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_msg_valid = 1'b0;
   logic [7:0] i_msg_chan = 8'h00, i_msg_cmd = 8'h00, i_msg_handle = 8'h00;
   logic [7:0] i_msg_words = 8'h00, i_pdu_delim = 8'h00, i_pdu_data_cnt = 8'h00;
   logic [39:0] i_pdu_addr = 40'h0;
   logic [3:0] i_chan_en = 4'hF, i_addr_known = 4'hF, i_info_busy = 4'h0;
   // Two seconds, so the held reply has to outlive one tick
   logic [7:0] i_timeout_sec = 8'h02;
   wire logic [159:0] i_dev_addr = {40'hC5111A0003, 40'hC5111A0002, 40'hC5111A0001, 40'hC5111A0000};
   wire logic fwd_done;
   wire logic [7:0] fwd_hdl;
   wire logic [15:0] fwd_len;
   logic o_fwd_valid, o_rsp_valid, o_rsp_data, dt, fv;
   logic [1:0] o_fwd_chan, fc;
   logic [7:0] o_fwd_handle, o_rsp_chan, o_rsp_status, o_rsp_handle, st, hd, fh;
   logic [15:0] o_rsp_count, cn;
   logic [3:0] o_chan_pending;
   int errors = 0;
   int checked = 0;

   hpm_handle_mgr #(.NCH(4), .SEC_CYCLES(20)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_msg_valid(i_msg_valid), .i_msg_chan(i_msg_chan), .i_msg_cmd(i_msg_cmd),
      .i_msg_handle(i_msg_handle), .i_msg_words(i_msg_words), .i_pdu_delim(i_pdu_delim),
      .i_pdu_addr(i_pdu_addr), .i_pdu_data_cnt(i_pdu_data_cnt), .i_chan_en(i_chan_en),
      .i_addr_known(i_addr_known), .i_info_busy(i_info_busy), .i_dev_addr(i_dev_addr),
      .i_timeout_sec(i_timeout_sec), .i_fwd_done(fwd_done), .i_fwd_handle(fwd_hdl),
      .i_fwd_len(fwd_len), .o_fwd_valid(o_fwd_valid), .o_fwd_chan(o_fwd_chan),
      .o_fwd_handle(o_fwd_handle), .o_rsp_valid(o_rsp_valid), .o_rsp_chan(o_rsp_chan),
      .o_rsp_status(o_rsp_status), .o_rsp_count(o_rsp_count), .o_rsp_handle(o_rsp_handle),
      .o_rsp_data(o_rsp_data), .o_chan_pending(o_chan_pending));
   hpm_fwd_model #(.LEN_BASE(LEN)) i_fwd (.i_clk(i_clk), .i_fwd_valid(o_fwd_valid),
      .i_fwd_chan(o_fwd_chan), .i_fwd_handle(o_fwd_handle), .i_dly(8'h08),
      .o_done(fwd_done), .o_handle(fwd_hdl), .o_len(fwd_len));

   always #10 i_clk = ~i_clk;

   task automatic send(input logic [7:0] ch, input logic [7:0] cmd, input logic [7:0] hdl);
      @(posedge i_clk);
      #1 i_msg_valid = 1'b1;
      i_msg_chan = ch;
      i_msg_cmd = cmd;
      i_msg_handle = hdl;
      @(posedge i_clk);
      #1 i_msg_valid = 1'b0;
      `CHK(o_rsp_valid, 1'b1)
      `CHK(o_rsp_chan, ch)
      {st, hd, cn, dt} = {o_rsp_status, o_rsp_handle, o_rsp_count, o_rsp_data};
      {fv, fc, fh} = {o_fwd_valid, o_fwd_chan, o_fwd_handle};
   endtask

   // Variant 1 bad delimiter, 2 wrong address, 3 word count one short of the packet
   task automatic req(input logic [7:0] ch, input int bad, input logic [7:0] es,
                      input logic [7:0] eh);
      i_pdu_delim = (bad == 1) ? 8'h86 : `HPM_DELIM_LONG;
      i_pdu_addr = i_dev_addr[ch[1:0]*40 +: 40] ^ ((bad == 2) ? 40'h1 : 40'h0);
      i_pdu_data_cnt = 8'h02;
      i_msg_words = (bad == 3) ? 8'h06 : 8'h07;
      send(ch, `HPM_CMD_REQUEST, 8'h00);
      `CHK(st, es)
      `CHK(hd, eh)
      `CHK(cn, 16'h0001)
      `CHK(fv, (es == `HPM_ST_ACCEPTED))
      if (fv === 1'b1) `CHK({fc, fh}, {ch[1:0], eh})
   endtask

   task automatic qry(input logic [7:0] ch, input logic [7:0] cmd, input logic [7:0] hdl,
                      input logic [7:0] es, input logic [15:0] ec);
      send(ch, cmd, hdl);
      `CHK(st, es)
      `CHK(hd, hdl)
      `CHK(cn, ec)
      `CHK(dt, (es == `HPM_ST_SUCCESS))
      `CHK(fv, 1'b0)
   endtask

   task automatic t_success();
      req(8'h00, 0, `HPM_ST_ACCEPTED, 8'h01);
      `CHK(o_chan_pending, 4'h1)
      qry(8'h00, `HPM_CMD_QUERY, 8'h01, `HPM_ST_PENDING, 16'h0001);
      repeat (14) @(posedge i_clk);
      #1 i_info_busy = 4'h1;
      qry(8'h00, `HPM_CMD_QUERY, 8'h01, `HPM_ST_REFUSED, 16'h0001);
      i_info_busy = 4'h0;
      qry(8'h00, `HPM_CMD_QUERY, 8'h01, `HPM_ST_SUCCESS, 16'h0001 + LEN);
      qry(8'h00, `HPM_CMD_QUERY, 8'h01, `HPM_ST_REFUSED, 16'h0001);
      `CHK(o_chan_pending, 4'h0)
      $display("test success done, mismatches %0d", errors);
   endtask

   task automatic t_refuse();
      for (int b = 1; b <= 3; b++)
         req(8'h02, b, `HPM_ST_REFUSED, 8'h00);
      req(8'h04, 0, `HPM_ST_REFUSED, 8'h00);
      i_chan_en = 4'hB;
      req(8'h02, 0, `HPM_ST_REFUSED, 8'h00);
      i_chan_en = 4'hF;
      i_addr_known = 4'hB;
      req(8'h02, 0, `HPM_ST_REFUSED, 8'h00);
      i_addr_known = 4'hF;
      i_info_busy = 4'h4;
      req(8'h02, 0, `HPM_ST_REFUSED, 8'h00);
      i_info_busy = 4'h0;
      $display("test refuse done, mismatches %0d", errors);
   endtask

   task automatic t_queue();
      // Zero is taken as one second
      i_timeout_sec = 8'h00;
      req(8'h01, 0, `HPM_ST_ACCEPTED, 8'h02);
      req(8'h01, 0, `HPM_ST_REFUSED, 8'h00);
      req(8'h02, 0, `HPM_ST_ACCEPTED, 8'h03);
      req(8'h03, 0, `HPM_ST_BUSY, 8'h00);
      qry(8'h01, 8'h0D, 8'h02, `HPM_ST_REFUSED, 16'h0001);
      qry(8'h01, `HPM_CMD_QUERY, 8'h03, `HPM_ST_REFUSED, 16'h0001);
      qry(8'h05, `HPM_CMD_QUERY, 8'h02, `HPM_ST_REFUSED, 16'h0001);
      repeat (60) @(posedge i_clk);
      #1 `CHK(o_chan_pending, 4'h0)
      qry(8'h01, `HPM_CMD_QUERY, 8'h02, `HPM_ST_REFUSED, 16'h0001);
      req(8'h03, 0, `HPM_ST_ACCEPTED, 8'h04);
      $display("test queue done, mismatches %0d", errors);
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // The tests need well under a thousand cycles
   initial begin
      repeat (3000) @(posedge i_clk);
      errors++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge i_clk);
      `CHK(o_rsp_status, `HPM_ST_REFUSED)
      #1 i_rstn = 1'b1;
      t_success();
      t_refuse();
      t_queue();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
